/* design/tlp_dev_end.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tlp_link_regs.svh"
module tlp_dev_end (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    tlp_link_if.dev lnk,
    // Configuration
    input wire logic is_switch,
    input wire logic is_upstream,
    input wire logic bridge_nond0,
    input wire logic [31:0] bar_base,
    input wire logic [31:0] bar_mask,
    input wire logic [11:0] max_payload,
    input wire logic [11:0] max_read,
    // Outstanding request tracking
    input wire logic [7:0] out_tag,
    input wire logic [2:0] out_tc,
    input wire logic out_issue,
    // User side
    output tlp_link_pkg::tlp_t usr_tlp,
    output logic usr_valid,
    input wire logic usr_ready,
    output logic err_poison,
    output logic err_ur,
    output logic err_malformed,
    output logic err_unexp_cpl,
    output logic [11:0] cpld_credit,
    output logic timeout
);
    tlp_link_pkg::tlp_t rx, rsp_r, fifo_in;
    logic [255:0] pend_r;
    logic [2:0] ptc_r [256];
    logic rsp_vld_r, e_p_r, e_u_r, e_m_r, e_x_r, fin_ready;
    logic [15:0] tmo_r;
    assign rx = lnk.dn_tlp;
    wire take = lnk.dn_valid && lnk.dn_ready;
    wire is_cpl = rx.kind == tlp_link_pkg::K_CPL;
    wire is_msg = rx.kind == tlp_link_pkg::K_MSG;
    wire is_memio = rx.kind == tlp_link_pkg::K_MWR
        || rx.kind == tlp_link_pkg::K_MRD || rx.kind == tlp_link_pkg::K_IO;
    wire poison = rx.ep && rx.has_data; // R1 R2
    wire hit = (rx.addr & bar_mask) == (bar_base & bar_mask);
    wire fn_ok = rx.func < `TLP_NFUNC; // R8
    // Non-D0 bridge blocks memory/IO and type 1 config only
    wire br_ur = is_switch && bridge_nond0
        && (is_memio || rx.kind == tlp_link_pkg::K_CFG1); // R10 R11 R12
    wire claim = is_memio ? hit && !br_ur // R7
        : rx.kind == tlp_link_pkg::K_CFG0 ? fn_ok
        : rx.kind == tlp_link_pkg::K_CFG1 ? is_switch && !br_ur : 1'b0;
    wire unsup = !is_cpl && !is_msg && !claim; // R6 R9
    wire needs_cpl = unsup && rx.kind != tlp_link_pkg::K_MWR;
    wire unexp = is_cpl && (!pend_r[rx.tag]
        || ptc_r[rx.tag] != rx.tc); // R13 R14
    wire bad_msg = is_switch && is_msg && rx.route == `TLP_ROUTE_GATHER
        && (rx.msg_code != `TLP_MSG_PME_ACK || is_upstream); // R16
    // Reserved routes and local route stay here (R15)
    wire msg_local = is_msg && !bad_msg && (rx.route == `TLP_ROUTE_LOCAL
        || rx.route > `TLP_ROUTE_GATHER); // R15
    wire to_user = take && !unsup && !unexp && !bad_msg;
    // Completions bypass the stall so their reception never waits on sends
    assign lnk.dn_ready = is_cpl || (fin_ready && !rsp_vld_r); // R19 R20 R21
    always_comb begin
        fifo_in = rx;
        fifo_in.route = msg_local ? `TLP_ROUTE_LOCAL : rx.route;
    end
    tlp_fifo #(.W($bits(tlp_link_pkg::tlp_t)), .D(`TLP_FIFO_DEPTH),
        .AW(`TLP_FIFO_AW)) u_fifo (
        .clk(clk), .rst(rst),
        .in_data(fifo_in), .in_valid(to_user), .in_ready(fin_ready),
        .out_data(usr_tlp), .out_valid(usr_valid), .out_ready(usr_ready));
    assign lnk.up_tlp = rsp_r;
    assign lnk.up_valid = rsp_vld_r;
    assign err_poison = e_p_r;
    assign err_ur = e_u_r;
    assign err_malformed = e_m_r;
    assign err_unexp_cpl = e_x_r;
    assign timeout = tmo_r == `TLP_TIMEOUT_CYC;
    wire [15:0] mp_units = 16'(max_payload) / `TLP_FC_UNIT;
    assign cpld_credit = !is_switch ? `TLP_CPLD_INF // R18
        : (mp_units < 16'(max_read) ? mp_units[11:0] : max_read); // R17
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            e_p_r <= 1'b0;
            e_u_r <= 1'b0;
            e_m_r <= 1'b0;
            e_x_r <= 1'b0;
            rsp_vld_r <= 1'b0;
            rsp_r <= '0;
            pend_r <= '0;
            tmo_r <= '0;
        end else begin
            e_p_r <= take && poison; // R4
            e_u_r <= take && unsup; // R6
            e_m_r <= take && bad_msg; // R16
            e_x_r <= take && unexp; // R13
            if (rsp_vld_r && lnk.up_ready) rsp_vld_r <= 1'b0;
            if (take && needs_cpl) begin
                rsp_vld_r <= 1'b1;
                rsp_r <= '0;
                rsp_r.kind <= tlp_link_pkg::K_CPL;
                rsp_r.tc <= rx.tc; // R22
                rsp_r.tag <= rx.tag;
                rsp_r.status <= tlp_link_pkg::ST_UR; // R6
            end
            if (take && is_cpl && !unexp) pend_r[rx.tag] <= 1'b0;
            if (out_issue) pend_r[out_tag] <= 1'b1;
            // Timer pauses in non-D0 L1 rather than expiring (R5)
            if (pend_r == '0) tmo_r <= '0;
            else if (!lnk.l1_nond0 && tmo_r != `TLP_TIMEOUT_CYC)
                tmo_r <= tmo_r + 16'h0001; // R5
        end
    end
    always_ff @(posedge clk) begin
        if (out_issue) ptc_r[out_tag] <= out_tc;
    end
endmodule
`default_nettype wire

/* design/tlp_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module tlp_fifo #(
    parameter int W = 8,
    parameter int D = 8,
    parameter int AW = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wp_r, rp_r;
    logic [AW:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    // Count is one bit wider than the pointers so full and empty differ
    assign in_ready = cnt_r != (AW+1)'(D);
    assign out_valid = cnt_r != '0;
    assign out_data = mem_r[rp_r];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wp_r <= wp_r + 1'b1;
            if (pop) rp_r <= rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge clk) begin
        if (push) mem_r[wp_r] <= in_data;
    end
endmodule
`default_nettype wire

/* design/tlp_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tlp_link_if;
    tlp_link_pkg::tlp_t dn_tlp;
    logic dn_valid;
    logic dn_ready;
    tlp_link_pkg::tlp_t up_tlp;
    logic up_valid;
    logic up_ready;
    logic l1_nond0;
    modport dev (input dn_tlp, input dn_valid, output dn_ready,
        output up_tlp, output up_valid, input up_ready, input l1_nond0);
    modport partner (output dn_tlp, output dn_valid, input dn_ready,
        input up_tlp, input up_valid, output up_ready, output l1_nond0);
endinterface
`default_nettype wire

/* design/tlp_link_pkg.sv */
package tlp_link_pkg;
    typedef enum logic [2:0] {
        K_MWR = 3'h0, K_MRD = 3'h1, K_IO = 3'h2, K_CFG0 = 3'h3,
        K_CFG1 = 3'h4, K_MSG = 3'h5, K_CPL = 3'h6, K_OTHER = 3'h7
    } kind_t;
    typedef enum logic [1:0] {
        ST_SC = 2'h0, ST_UR = 2'h1, ST_CA = 2'h2
    } cpl_st_t;
    typedef struct packed {
        kind_t kind;
        logic ep;
        logic has_data;
        logic [2:0] tc;
        logic [7:0] tag;
        logic [2:0] func;
        logic [2:0] route;
        logic [7:0] msg_code;
        logic [1:0] status;
        logic [31:0] addr;
        logic [31:0] data;
    } tlp_t;
endpackage

/* design/tlp_link_regs.svh */
// Overview of operation
// R1: EP bit one marks TLP poisoned
// R2: EP set only on payload TLPs
// R3: Known bad payload must carry EP
// R4: Poisoned receipt reports error at receiver
// R5: Non-D0 L1 pauses FC, timeout timers
// R6: Unsupported type is UR, completed UR
// R7: Type 0 claims memory/IO only on hit
// R8: Unimplemented function config not claimed
// R9: Completer Abort only for claimed requests
// R10: Non-D0 bridge URs downstream memory/IO
// R11: Non-D0 bridge URs type 1 config
// R12: Completions, messages ignore bridge power state
// R13: Unmatched tag completion is unexpected
// R14: Other mismatch may be unexpected completion
// R15: Route 100b or reserved processed locally
// R16: 101b only PME ack, not upstream
// R17: Switch advertises min completion data credit
// R18: Endpoint advertises infinite completion credit
// R19: Posted/completion not blocked by non-posted (posted requests here share the FIFO and UR stall with non-posted)
// R20: Acceptance independent of same-class transmission
// R21: Endpoint never blocks completion acceptance
// R22: Completion returned in request traffic class
`ifndef TLP_LINK_REGS_SVH
`define TLP_LINK_REGS_SVH
`define TLP_FIFO_DEPTH 8
`define TLP_FIFO_AW 3
`define TLP_ROUTE_LOCAL 3'h4
`define TLP_ROUTE_GATHER 3'h5
`define TLP_MSG_PME_ACK 8'h1B
`define TLP_TIMEOUT_CYC 16'h0FFF
`define TLP_FC_UPD_CYC 16'h00FF
`define TLP_FC_UNIT 16'h0010
`define TLP_CPLD_INF 12'h000
`define TLP_NFUNC 3'h1
`endif

/* design/tlp_partner_end.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tlp_link_regs.svh"
module tlp_partner_end (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    tlp_link_if.partner lnk,
    // User side
    input wire tlp_link_pkg::tlp_t req_tlp,
    input wire logic req_valid,
    input wire logic req_bad,
    output logic req_ready,
    input wire logic in_l1_nond0,
    output tlp_link_pkg::tlp_t rsp_tlp,
    output logic rsp_valid,
    output logic fc_update
);
    tlp_link_pkg::tlp_t tx_r, rsp_r;
    logic vld_r, rv_r, l1_r;
    logic [15:0] fc_r;
    assign lnk.dn_tlp = tx_r;
    assign lnk.dn_valid = vld_r;
    assign lnk.l1_nond0 = l1_r;
    assign req_ready = !vld_r || lnk.dn_ready;
    // Accept responses unconditionally so they never wait on sends
    assign lnk.up_ready = 1'b1; // R20 R21
    assign rsp_tlp = rsp_r;
    assign rsp_valid = rv_r;
    // A pause landing on the terminal count must not hold the pulse high
    assign fc_update = fc_r == `TLP_FC_UPD_CYC && !l1_r; // R5
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_r <= '0;
            vld_r <= 1'b0;
            rsp_r <= '0;
            rv_r <= 1'b0;
            l1_r <= 1'b0;
            fc_r <= '0;
        end else begin
            l1_r <= in_l1_nond0;
            rv_r <= lnk.up_valid;
            if (lnk.up_valid) rsp_r <= lnk.up_tlp;
            if (req_valid && req_ready) begin
                vld_r <= 1'b1;
                tx_r <= req_tlp;
                tx_r.ep <= req_tlp.has_data && req_bad; // R2 R3
            end else if (lnk.dn_ready) begin
                vld_r <= 1'b0;
            end
            if (l1_r) fc_r <= fc_r; // R5
            else if (fc_update) fc_r <= '0;
            else fc_r <= fc_r + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* test/tlp_link_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module tlp_link_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Partner to device
    input wire tlp_link_pkg::tlp_t dn_tlp,
    input wire logic dn_valid,
    input wire logic dn_ready,
    // Device to partner
    input wire tlp_link_pkg::tlp_t up_tlp,
    input wire logic up_valid,
    input wire logic up_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire is_cpl = dn_tlp.kind == tlp_link_pkg::K_CPL;
    wire is_cfg0 = dn_tlp.kind == tlp_link_pkg::K_CFG0;
    // Completions ignore the FIFO's ready, so a full FIFO cannot deadlock them
    chk_cpl_no_stall: assert property (dn_valid && is_cpl |-> dn_ready)
        else $error("completion not accepted");
    chk_ep_has_data: assert property (
        dn_valid && dn_tlp.ep |-> dn_tlp.has_data)
        else $error("poison flag on payload-free packet");
    chk_dn_holds: assert property (
        dn_valid && !dn_ready |=> dn_valid && $stable(dn_tlp))
        else $error("downstream packet changed while waiting");
    chk_up_holds: assert property (
        up_valid && !up_ready |=> up_valid && $stable(up_tlp))
        else $error("upstream packet changed while waiting");
    chk_up_ur_cpl: assert property (
        up_valid |-> up_tlp.kind == tlp_link_pkg::K_CPL && !up_tlp.ep
        && up_tlp.status == tlp_link_pkg::ST_UR)
        else $error("upstream answer is not a plain UR completion");
    chk_cfg_ur_tc: assert property (
        dn_valid && dn_ready && is_cfg0 && dn_tlp.func != 3'h0 |=> up_valid
        && up_tlp.tag == $past(dn_tlp.tag) && up_tlp.tc == $past(dn_tlp.tc))
        else $error("unclaimed config got no matching UR completion");
    chk_ur_refuse: assert property (up_valid && !is_cpl |-> !dn_ready)
        else $error("request taken while UR answer pending");
    chk_ur_single: assert property (up_valid && up_ready |=> !up_valid)
        else $error("UR answer repeated");
endmodule
`default_nettype wire

/* test/tlp_receive_handling_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module tlp_receive_handling_bench;
    typedef struct packed {
        logic [2:0] k;
        logic [2:0] fn;
        logic [2:0] rt;
        logic [7:0] mc;
        logic [4:0] f;
        logic [3:0] e;
    } row_t;
    logic clk, rst, sw, nd0, usr_ready, req_valid, req_bad, in_l1, ok;
    logic out_issue, req_ready, usr_valid, timeout, e_p, e_u, e_m, e_x;
    logic fc_update;
    logic [2:0] last_rt;
    logic [2:0] out_tc;
    logic [7:0] out_tag;
    logic [11:0] mps, mrd, credit;
    logic [3:0] seen;
    tlp_link_pkg::tlp_t req_tlp, t, usr_tlp;
    int mismatches, check_count, got, fc_n, sent;
    // Flags: bar hit, payload, bad data, switch, bridge non-D0
    row_t rows [14] = '{'{3'h0, 3'h0, 3'h0, 8'h00, 5'h1C, 4'h8},
        '{3'h0, 3'h0, 3'h0, 8'h00, 5'h18, 4'h0},
        '{3'h1, 3'h0, 3'h0, 8'h00, 5'h00, 4'h4},
        '{3'h3, 3'h1, 3'h0, 8'h00, 5'h00, 4'h4},
        '{3'h3, 3'h0, 3'h0, 8'h00, 5'h00, 4'h0},
        '{3'h4, 3'h0, 3'h0, 8'h00, 5'h00, 4'h4},
        '{3'h7, 3'h0, 3'h0, 8'h00, 5'h00, 4'h4},
        '{3'h1, 3'h0, 3'h0, 8'h00, 5'h14, 4'h0},
        '{3'h0, 3'h0, 3'h0, 8'h00, 5'h1B, 4'h4},
        '{3'h4, 3'h0, 3'h0, 8'h00, 5'h03, 4'h4},
        '{3'h5, 3'h0, 3'h5, 8'h00, 5'h02, 4'h2},
        '{3'h5, 3'h0, 3'h5, 8'h1B, 5'h03, 4'h0},
        '{3'h6, 3'h0, 3'h0, 8'h00, 5'h00, 4'h1},
        '{3'h5, 3'h0, 3'h6, 8'h00, 5'h02, 4'h0}};
    tlp_link_if lnk();
    tlp_dev_end u_tlp_dev_end (.clk(clk), .rst(rst), .lnk(lnk.dev),
        .is_switch(sw), .is_upstream(1'h0), .bridge_nond0(nd0),
        .bar_base(32'h1000_0000), .bar_mask(32'hFFFF_0000),
        .max_payload(mps), .max_read(mrd), .out_tag(out_tag),
        .out_tc(out_tc), .out_issue(out_issue), .usr_tlp(usr_tlp),
        .usr_valid(usr_valid), .usr_ready(usr_ready), .err_poison(e_p),
        .err_ur(e_u), .err_malformed(e_m), .err_unexp_cpl(e_x),
        .cpld_credit(credit), .timeout(timeout));
    tlp_partner_end u_tlp_partner_end (.clk(clk), .rst(rst),
        .lnk(lnk.partner), .req_tlp(req_tlp), .req_valid(req_valid),
        .req_bad(req_bad), .req_ready(req_ready), .in_l1_nond0(in_l1),
        .rsp_tlp(), .rsp_valid(), .fc_update(fc_update));
    tlp_link_chk u_tlp_link_chk (.clk(clk), .rst(rst),
        .dn_tlp(lnk.dn_tlp), .dn_valid(lnk.dn_valid),
        .dn_ready(lnk.dn_ready), .up_tlp(lnk.up_tlp),
        .up_valid(lnk.up_valid), .up_ready(lnk.up_ready));
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        seen <= seen | {e_p, e_u, e_m, e_x};
        if (usr_valid && usr_ready) got <= got + 1;
        if (usr_valid && usr_ready) last_rt <= usr_tlp.route;
        if (fc_update) fc_n <= fc_n + 1;
    end
    task check(string n, logic [11:0] s, logic [11:0] x);
        check_count++;
        if (s !== x) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask
    // A refused request stays raised so it is never withdrawn unanswered
    task xfer(tlp_link_pkg::tlp_t v, logic b, int lim);
        @(posedge clk);
        req_tlp <= v;
        req_bad <= b;
        req_valid <= 1'h1;
        ok = 1'h0;
        for (int n = 0; n < lim && !ok; n++) begin
            @(posedge clk);
            ok = req_ready;
        end
        if (ok) req_valid <= 1'h0;
    endtask
    task run(string n, logic b, logic [3:0] x);
        @(negedge clk) seen = 4'h0;
        xfer(t, b, 300);
        repeat (20) @(posedge clk);
        check(n, seen, x);
        $display("done %s", n);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    initial begin
        {rst, sw, nd0, req_valid, req_bad, in_l1, out_issue} = 7'h40;
        {usr_ready, out_tc, out_tag, mps, mrd, req_tlp, t} = '0;
        usr_ready = 1'h1;
        {seen, got, fc_n, sent} = '0;
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        for (int i = 0; i < 14; i++) begin
            t = '0;
            t.kind = tlp_link_pkg::kind_t'(rows[i].k);
            t.func = rows[i].fn;
            t.route = rows[i].rt;
            t.msg_code = rows[i].mc;
            {t.has_data, t.tag, t.tc} = {rows[i].f[3], 8'(i), 3'(i)};
            t.addr = rows[i].f[4] ? 32'h1000_0040 : 32'h2000_0000;
            {sw, nd0} <= rows[i].f[1:0];
            run($sformatf("row %0d", i), rows[i].f[2], rows[i].e);
        end
        // Last row uses a reserved route, which must come out marked local
        check("local route", last_rt, 12'h004);
        {sw, nd0, out_tag, out_tc, out_issue} <= {2'h0, 8'h40, 3'h1, 1'h1};
        @(posedge clk) out_issue <= 1'h0;
        t = '0;
        t.kind = tlp_link_pkg::K_CPL;
        t.tag = 8'h40;
        t.tc = 3'h2;
        run("tc mismatch", 1'h0, 4'h1);
        // Too few stall cycles would hide a timer that never pauses
        in_l1 <= 1'h1;
        repeat (4) @(posedge clk);
        fc_n <= 0;
        repeat (4600) @(posedge clk);
        check("l1 pause", {fc_n[10:0], timeout}, 12'h000);
        in_l1 <= 1'h0;
        repeat (4600) @(posedge clk);
        check("l1 resume", {fc_n > 12, timeout}, 12'h003);
        t = '0;
        {t.has_data, t.addr} = {1'h1, 32'h1000_0080};
        usr_ready <= 1'h0;
        got <= 0;
        for (ok = 1'h1; ok; sent++) xfer(t, 1'h0, 30);
        check("full", {lnk.dn_valid, lnk.dn_ready, sent > 7}, 12'h005);
        usr_ready <= 1'h1;
        xfer(t, 1'h0, 300);
        repeat (40) @(posedge clk);
        check("drained", 12'(got), 12'(sent));
        {sw, mps, mrd} <= {1'h0, 12'h100, 12'h008};
        @(negedge clk) check("endpoint credit", credit, 12'h000);
        @(posedge clk) sw <= 1'h1;
        @(negedge clk) check("switch credit", credit, 12'h008);
        @(posedge clk) mrd <= 12'h200;
        @(negedge clk) check("payload credit", credit, 12'h010);
        // Tag 40h is still outstanding, so the timer stays expired
        @(negedge clk) check("timer held", timeout, 12'h001);
        @(posedge clk) rst <= 1'h1;
        @(negedge clk) check("reset", {usr_valid, timeout}, 12'h000);
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        t = '0;
        t.kind = tlp_link_pkg::K_MRD;
        run("after reset", 1'h0, 4'h4);
        give_verdict();
    end
endmodule
`default_nettype wire
